// [gcr_pkg.sv]
/*
  Constants for the pin configuration and primary reset trigger block:
  register offsets, field layout, reset values, hold-time encodings.
  Assumes a 125 MHz system clock.
*/
`default_nettype none
package gcr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_UPPER_DRIVE_STYLE = 8'h26;
  localparam logic [7:0] OFS_LOWER_DIRECTION   = 8'h27;
  localparam logic [7:0] OFS_UPPER_DIRECTION   = 8'h28;
  localparam logic [7:0] OFS_SLOT_ONE          = 8'h29;
  localparam logic [7:0] OFS_SLOT_TWO          = 8'h2A;
  localparam logic [7:0] OFS_SLOT_THREE        = 8'h2B;

  // ==========================================================
  // Field layout and write masks
  localparam int         LEVEL_BIT       = 7;
  localparam int         CODE_MSB        = 6;
  localparam int         NUM_SLOTS       = 3;
  localparam logic [6:0] CODE_UNUSED     = 7'h00;
  localparam logic [7:0] MASK_LOWER_SIX  = 8'h3F;
  localparam logic [7:0] MASK_LOWER_FIVE = 8'h1F;
  localparam logic [7:0] MASK_UPPER_FIVE = 8'h1F;
  localparam logic [7:0] MASK_SLOT       = 8'hFF;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;

  // ==========================================================
  // Hold duration encodings
  localparam logic [2:0] HOLD_IMMEDIATE = 3'h0;
  localparam logic [2:0] HOLD_ONE       = 3'h1;
  localparam logic [2:0] HOLD_ONE_HALF  = 3'h2;
  localparam logic [2:0] HOLD_TWO       = 3'h3;

  // ==========================================================
  // Timing: times in milliseconds, counts derived from clock rate
  localparam longint CLK_HZ          = 125000000;
  localparam longint HOLD_ONE_MS     = 1000;
  localparam longint HOLD_ONE_HALF_MS = 1500;
  localparam longint HOLD_TWO_MS     = 2000;
  localparam int     HOLD_ONE_CYC      = int'(HOLD_ONE_MS * CLK_HZ / 1000);
  localparam int     HOLD_ONE_HALF_CYC = int'(HOLD_ONE_HALF_MS * CLK_HZ / 1000);
  localparam int     HOLD_TWO_CYC      = int'(HOLD_TWO_MS * CLK_HZ / 1000);
  localparam int     CNT_W             = 28;

  // ==========================================================
  // Trigger sequencer states
  typedef enum logic [2:0] {
    GCR_IDLE  = 3'b001,
    GCR_HOLD  = 3'b010,
    GCR_FIRED = 3'b100
  } gcr_state_t;
endpackage : gcr_pkg
`default_nettype wire

// [gcr_top.sv]
/*
  Pin direction registers for pins 1..11, a drive style register for
  pins 7..11, and the primary reset trigger logic with three event slots.
  Assumes an upstream serial-port engine delivering byte register
  accesses, an event source presenting one event per cycle, and the
  shared reset configuration bits arriving as plain inputs.
  Hold counts default to full-length times at the system clock; a
  bench may shrink them through the parameters. Hold codes above the
  two-second one act as immediate. Pin six exists only when
  PIN_SIX_PRESENT is set; otherwise its direction bit stays zero and
  the pin remains an input.
*/
`timescale 1ns/1ps
`default_nettype none
module gcr_top #(
  parameter int HOLD_ONE_CYC      = gcr_pkg::HOLD_ONE_CYC,      // 1.0 s count
  parameter int HOLD_ONE_HALF_CYC = gcr_pkg::HOLD_ONE_HALF_CYC, // 1.5 s count
  parameter int HOLD_TWO_CYC      = gcr_pkg::HOLD_TWO_CYC,      // 2.0 s count
  parameter bit PIN_SIX_PRESENT   = 1'b1                        // Variant with pin 6
) (
  input  wire logic        clk,                          // System clock
  input  wire logic        rst_n,                        // Async reset, low
  input  wire logic        reg_we,                       // Register write strobe
  input  wire logic [7:0]  reg_addr,                     // Register offset
  input  wire logic [7:0]  reg_wdata,                    // Write byte
  output logic      [7:0]  reg_rdata,                    // Read byte, next cycle
  input  wire logic [10:0] gpo_data,                     // Output data, pins 11..1
  input  wire logic [5:0]  lower_drive_style,            // Drive style, pins 6..1
  input  wire logic [10:0] general_input_pin,            // Pin input levels
  output logic      [10:0] pin_out,                      // Pin output value
  output logic      [10:0] pin_oe,                       // Pin output enable
  output logic      [10:0] pin_in_level,                 // Sampled input levels
  input  wire logic        event_valid,                  // Event present
  input  wire logic [6:0]  event_code,                   // Event identity
  input  wire logic        event_level,                  // 1 active/press
  input  wire logic        event_is_key,                 // Event is a key
  input  wire logic [2:0]  trigger_hold_duration,        // Shared hold time
  input  wire logic        primary_reset_polarity,       // 1 active high
  input  wire logic        external_reset_merge_enable,  // Merge external reset
  input  wire logic        ext_reset_n,                  // External reset pin, low
  output logic             primary_reset_output,         // Primary reset pin
  output logic [2:0]       slot_match                    // Per-slot match flags
);

  // ==========================================================
  // Register file
  logic [7:0] upper_pin_drive_style;
  logic [7:0] lower_pin_direction;
  logic [7:0] upper_pin_direction;
  logic [7:0] slot_cfg      [gcr_pkg::NUM_SLOTS];

  // Next values and write side effects
  logic [7:0] next_upper_pin_drive_style;
  logic [7:0] next_lower_pin_direction;
  logic [7:0] next_upper_pin_direction;
  logic [7:0] next_slot_cfg [gcr_pkg::NUM_SLOTS];
  logic [7:0] next_reg_rdata;
  logic [2:0] slot_written;
  logic [7:0] lower_mask;

  // Pin six bit only writable on variants that bond it out
  assign lower_mask = PIN_SIX_PRESENT ? gcr_pkg::MASK_LOWER_SIX : gcr_pkg::MASK_LOWER_FIVE;

  // Write decode with reserved bits forced to zero; read mux
  always_comb begin
    next_upper_pin_drive_style = upper_pin_drive_style;
    next_lower_pin_direction   = lower_pin_direction;
    next_upper_pin_direction   = upper_pin_direction;
    next_slot_cfg              = slot_cfg;
    slot_written               = 3'h0;
    if (reg_we) begin
      case (reg_addr)
        gcr_pkg::OFS_UPPER_DRIVE_STYLE: begin
          next_upper_pin_drive_style = reg_wdata & gcr_pkg::MASK_UPPER_FIVE;
        end
        gcr_pkg::OFS_LOWER_DIRECTION: begin
          next_lower_pin_direction = reg_wdata & lower_mask;
        end
        gcr_pkg::OFS_UPPER_DIRECTION: begin
          next_upper_pin_direction = reg_wdata & gcr_pkg::MASK_UPPER_FIVE;
        end
        gcr_pkg::OFS_SLOT_ONE: begin
          next_slot_cfg[0] = reg_wdata & gcr_pkg::MASK_SLOT;
          slot_written[0]  = 1'b1;
        end
        gcr_pkg::OFS_SLOT_TWO: begin
          next_slot_cfg[1] = reg_wdata & gcr_pkg::MASK_SLOT;
          slot_written[1]  = 1'b1;
        end
        gcr_pkg::OFS_SLOT_THREE: begin
          next_slot_cfg[2] = reg_wdata & gcr_pkg::MASK_SLOT;
          slot_written[2]  = 1'b1;
        end
        default: begin
        end
      endcase
    end

    // Read data trails the address by one edge; holes read zero
    case (reg_addr)
      gcr_pkg::OFS_UPPER_DRIVE_STYLE: next_reg_rdata = upper_pin_drive_style;
      gcr_pkg::OFS_LOWER_DIRECTION:   next_reg_rdata = lower_pin_direction;
      gcr_pkg::OFS_UPPER_DIRECTION:   next_reg_rdata = upper_pin_direction;
      gcr_pkg::OFS_SLOT_ONE:          next_reg_rdata = slot_cfg[0];
      gcr_pkg::OFS_SLOT_TWO:          next_reg_rdata = slot_cfg[1];
      gcr_pkg::OFS_SLOT_THREE:        next_reg_rdata = slot_cfg[2];
      default:                        next_reg_rdata = 8'h00;
    endcase
  end

  // Register storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upper_pin_drive_style <= gcr_pkg::RST_CONFIG;
      lower_pin_direction   <= gcr_pkg::RST_CONFIG;
      upper_pin_direction   <= gcr_pkg::RST_CONFIG;
      slot_cfg[0]           <= gcr_pkg::RST_CONFIG;
      slot_cfg[1]           <= gcr_pkg::RST_CONFIG;
      slot_cfg[2]           <= gcr_pkg::RST_CONFIG;
      reg_rdata             <= 8'h00;
    end else begin
      upper_pin_drive_style <= next_upper_pin_drive_style;
      lower_pin_direction   <= next_lower_pin_direction;
      upper_pin_direction   <= next_upper_pin_direction;
      slot_cfg              <= next_slot_cfg;
      reg_rdata             <= next_reg_rdata;
    end
  end

  // ==========================================================
  // Pin drivers
  // Resolved per-pin configuration, bit 0 is pin 1
  logic [10:0] dir_all;
  logic [10:0] style_all;
  logic [10:0] next_pin_out;
  logic [10:0] next_pin_oe;

  // Upper group fills bits 10:6; reserved bits never reach a pin
  assign dir_all   = {upper_pin_direction[4:0], lower_pin_direction[5:0]};
  assign style_all = {upper_pin_drive_style[4:0], lower_drive_style};

  // Open-drain never drives high, so a wired line can be pulled up
  always_comb begin
    for (int i = 0; i < 11; i++) begin
      if (!dir_all[i]) begin
        next_pin_out[i] = 1'b0;
        next_pin_oe[i]  = 1'b0;
      end else if (style_all[i]) begin
        next_pin_out[i] = 1'b0;
        next_pin_oe[i]  = ~gpo_data[i];
      end else begin
        next_pin_out[i] = gpo_data[i];
        next_pin_oe[i]  = 1'b1;
      end
    end
  end

  // Pin flops; inputs sampled for readers elsewhere
  // No debounce or filtering here: levels pass after one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_out      <= 11'h000;
      pin_oe       <= 11'h000;
      pin_in_level <= 11'h000;
    end else begin
      pin_out      <= next_pin_out;
      pin_oe       <= next_pin_oe;
      pin_in_level <= general_input_pin;
    end
  end

  // ==========================================================
  // Per-slot match flags
  // Flags and in-use marks, one bit per slot
  logic [2:0] next_slot_match;
  logic [2:0] slot_used;

  // Set wins over clear: a matching event beats a config write
  // Unused slots keep their flag low so they never block a match
  for (genvar s = 0; s < gcr_pkg::NUM_SLOTS; s++) begin : g_slot
    logic hit;
    logic miss;
    assign slot_used[s] = slot_cfg[s][gcr_pkg::CODE_MSB:0] != gcr_pkg::CODE_UNUSED;
    // Hit: used slot, same code, same level, never a key release
    assign hit  = event_valid && slot_used[s]
               && (event_code == slot_cfg[s][gcr_pkg::CODE_MSB:0])
               && (event_level == slot_cfg[s][gcr_pkg::LEVEL_BIT])
               && !(event_is_key && !event_level);
    // Same code at the other level ends the held condition
    assign miss = event_valid && (event_code == slot_cfg[s][gcr_pkg::CODE_MSB:0])
               && (event_level != slot_cfg[s][gcr_pkg::LEVEL_BIT]);
    always_comb begin
      if (hit) begin
        next_slot_match[s] = 1'b1;
      end else if (miss || slot_written[s] || !slot_used[s]) begin
        next_slot_match[s] = 1'b0;
      end else begin
        next_slot_match[s] = slot_match[s];
      end
    end
  end

  // Match flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_match <= 3'h0;
    end else begin
      slot_match <= next_slot_match;
    end
  end

  // ==========================================================
  // Hold timer and trigger sequencer
  // Count width covers the two-second code at the system clock
  gcr_pkg::gcr_state_t         state;
  gcr_pkg::gcr_state_t         next_state;
  logic [gcr_pkg::CNT_W-1:0]   hold_cnt;
  logic [gcr_pkg::CNT_W-1:0]   next_hold_cnt;
  logic [gcr_pkg::CNT_W-1:0]   hold_limit;
  logic                        all_match;
  logic                        fired;
  logic                        asserted;
  logic                        next_reset_out;

  // Lone matching slot must not fire while others are in use
  assign all_match = (slot_used != 3'h0) && ((slot_match & slot_used) == slot_used);

  // Undefined encodings behave as immediate
  // Limit is read every cycle, so a change mid-hold acts at once
  always_comb begin
    case (trigger_hold_duration)
      gcr_pkg::HOLD_ONE:      hold_limit = gcr_pkg::CNT_W'(HOLD_ONE_CYC);
      gcr_pkg::HOLD_ONE_HALF: hold_limit = gcr_pkg::CNT_W'(HOLD_ONE_HALF_CYC);
      gcr_pkg::HOLD_TWO:      hold_limit = gcr_pkg::CNT_W'(HOLD_TWO_CYC);
      default:                hold_limit = '0;
    endcase
  end

  // Any drop of the joint condition restarts the hold
  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    case (state)
      gcr_pkg::GCR_IDLE: begin
        next_hold_cnt = '0;
        if (all_match) begin
          next_state = (hold_limit == '0) ? gcr_pkg::GCR_FIRED : gcr_pkg::GCR_HOLD;
        end
      end
      gcr_pkg::GCR_HOLD: begin
        if (!all_match) begin
          next_state = gcr_pkg::GCR_IDLE;
        end else if (hold_cnt + 1'b1 >= hold_limit) begin
          next_state = gcr_pkg::GCR_FIRED;
        end else begin
          next_hold_cnt = hold_cnt + 1'b1;
        end
      end
      gcr_pkg::GCR_FIRED: begin
        if (!all_match) begin
          next_state = gcr_pkg::GCR_IDLE;
        end
      end
      default: begin
        next_state = gcr_pkg::GCR_IDLE;
      end
    endcase
  end

  // External merge and polarity applied after the sequencer
  assign fired          = state == gcr_pkg::GCR_FIRED;
  assign asserted       = fired || (external_reset_merge_enable && !ext_reset_n);
  assign next_reset_out = primary_reset_polarity ? asserted : !asserted;

  // Output idles deasserted low-active until polarity is applied
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state                <= gcr_pkg::GCR_IDLE;
      hold_cnt             <= '0;
      primary_reset_output <= 1'b1;
    end else begin
      state                <= next_state;
      hold_cnt             <= next_hold_cnt;
      primary_reset_output <= next_reset_out;
    end
  end

endmodule : gcr_top
`default_nettype wire

// [gcr_pad_model.sv]
/*
  Pin pad model beside the block: resolves each pin from its output
  value and enable, with a pull-up on every pin.
  Assumes pin_out and pin_oe come straight from gcr_top.
*/
`timescale 1ns/1ps
`default_nettype none
module gcr_pad_model (
  input  wire logic [10:0] pin_out,           // Driven value
  input  wire logic [10:0] pin_oe,            // High while driven
  output logic      [10:0] general_input_pin  // Resolved pad level
);
  // ==========================================================
  // Released pins float up, so open-drain ones read high
  assign general_input_pin = (pin_oe & pin_out) | ~pin_oe;
endmodule : gcr_pad_model
`default_nettype wire

// [gcr_top_asserts.sv]
/*
  Concurrent checks on the ports of gcr_top.
  Assumes one clock domain; bound to every gcr_top instance.
*/
`timescale 1ns/1ps
`default_nettype none
module gcr_top_asserts #(
  parameter int HOLD_ONE_CYC = 10  // Count for hold code 001
) (
  input wire logic        clk,                          // Clock
  input wire logic        rst_n,                        // Reset, low
  input wire logic [7:0]  reg_addr,                     // Offset
  input wire logic [7:0]  reg_rdata,                    // Read byte
  input wire logic [10:0] gpo_data,                     // Output data
  input wire logic [10:0] general_input_pin,            // Pad levels
  input wire logic [10:0] pin_out,                      // Pin value
  input wire logic [10:0] pin_oe,                       // Pin enable
  input wire logic [10:0] pin_in_level,                 // Sampled levels
  input wire logic        event_valid,                  // Event strobe
  input wire logic [6:0]  event_code,                   // Event code
  input wire logic        event_level,                  // Event level
  input wire logic        event_is_key,                 // Key event
  input wire logic [2:0]  trigger_hold_duration,        // Hold code
  input wire logic        primary_reset_polarity,       // Polarity
  input wire logic        external_reset_merge_enable,  // Merge enable
  input wire logic        ext_reset_n,                  // External reset
  input wire logic        primary_reset_output,         // Reset out
  input wire logic [2:0]  slot_match                    // Match flags
);
  // ==========================================================
  // Cycles since a flag last rose while any stays set; a flag only
  // rises while the joint match is false, so this bounds the hold
  int         run;
  logic [2:0] prev_match;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run        <= 0;
      prev_match <= 3'h0;
    end else begin
      prev_match <= slot_match;
      if ((slot_match & ~prev_match) != 3'h0) begin
        run <= 1;
      end else begin
        run <= (slot_match != 3'h0) ? run + 1 : 0;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ext;
    external_reset_merge_enable && !ext_reset_n;
  endsequence
  sequence s_rise;
    (slot_match & ~$past(slot_match)) != 3'h0;
  endsequence
  property p_rsv_hi;
    ($past(reg_addr) == 8'h26 || $past(reg_addr) == 8'h28) |-> reg_rdata[7:5] == 3'h0;
  endproperty
  a_rsv_hi: assert property (p_rsv_hi) else $error("upper reserved bits read set");
  property p_rsv_lo;
    $past(reg_addr) == 8'h27 |-> reg_rdata[7:6] == 2'h0;
  endproperty
  a_rsv_lo: assert property (p_rsv_lo) else $error("lower reserved bits read set");
  property p_off_low;
    (pin_out & ~pin_oe) == 11'h000;
  endproperty
  a_off_low: assert property (p_off_low) else $error("undriven pin shows one");
  property p_low_data;
    $past(rst_n) |-> (pin_oe & ~pin_out & $past(gpo_data)) == 11'h000;
  endproperty
  a_low_data: assert property (p_low_data) else $error("pin pulled low for data one");
  property p_in_level;
    $past(rst_n) |-> pin_in_level == $past(general_input_pin);
  endproperty
  a_in_level: assert property (p_in_level) else $error("input level not one cycle late");
  property p_rise_evt;
    s_rise |-> $past(event_valid);
  endproperty
  a_rise_evt: assert property (p_rise_evt) else $error("match flag set without event");
  property p_key_rel;
    event_valid && event_is_key && !event_level |=> (slot_match & ~$past(slot_match)) == 3'h0;
  endproperty
  a_key_rel: assert property (p_key_rel) else $error("key release set a flag");
  property p_zero_code;
    event_valid && event_code == 7'h00 |=> (slot_match & ~$past(slot_match)) == 3'h0;
  endproperty
  a_zero_code: assert property (p_zero_code) else $error("code zero set a flag");
  property p_cause;
    $past(rst_n, 2) && !($past(external_reset_merge_enable) && !$past(ext_reset_n))
      && primary_reset_output == $past(primary_reset_polarity) |-> $past(slot_match, 2) != 3'h0;
  endproperty
  a_cause: assert property (p_cause) else $error("reset asserted with no match");
  property p_merge;
    s_ext |=> primary_reset_output == $past(primary_reset_polarity);
  endproperty
  a_merge: assert property (p_merge) else $error("external reset not merged");
  property p_hold;
    $past(trigger_hold_duration) == 3'h1 && $past(ext_reset_n)
      && primary_reset_output == $past(primary_reset_polarity) |-> run >= HOLD_ONE_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("reset before hold time");
endmodule : gcr_top_asserts
bind gcr_top gcr_top_asserts #(.HOLD_ONE_CYC(HOLD_ONE_CYC)) u_chk (.*);
`default_nettype wire

// [gcr_top_bench.sv]
/*
  Self-checking bench for gcr_top: register reads and writes, pins
  through the pad model, event sequences into the reset trigger.
  Assumes short hold counts so the run stays brief.
*/
`timescale 1ns/1ps
`default_nettype none
module gcr_top_bench;
  localparam int HL[4] = '{0, 10, 15, 20};
  localparam logic [7:0] MSK[6] = '{8'h1F, 8'h3F, 8'h1F, 8'hFF, 8'hFF, 8'hFF};
  logic        clk, rst_n, reg_we, event_valid, event_level, event_is_key;
  logic        primary_reset_polarity, external_reset_merge_enable, ext_reset_n, primary_reset_output;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [10:0] gpo_data, general_input_pin, pin_out, pin_oe, pin_in_level;
  logic [5:0]  lower_drive_style;
  logic [6:0]  event_code;
  logic [2:0]  trigger_hold_duration, slot_match;
  int          num_errors = 0;
  int          num_checks = 0;
  gcr_top #(.HOLD_ONE_CYC(HL[1]), .HOLD_ONE_HALF_CYC(HL[2]), .HOLD_TWO_CYC(HL[3])) u_dut (.*);
  gcr_pad_model u_pad (.*);
  // ==========================================================
  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic check(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // All tasks start and end 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Extra cycle keeps a strobe from being reassigned in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_we = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    tick(1);
    check({3'h0, reg_rdata}, {3'h0, exp});
  endtask : rd
  task automatic ev(input logic [6:0] c, input logic l, input logic k);
    event_valid = 1'b1;
    event_code = c;
    event_level = l;
    event_is_key = k;
    tick(1);
    event_valid = 1'b0;
    tick(1);
  endtask : ev
  // Watchdog, well past the expected run length
  initial begin
    #100000;
    num_errors++;
    results();
  end
  initial begin
    {rst_n, reg_we, reg_addr, reg_wdata, event_valid, event_code, event_level, event_is_key} = '0;
    {trigger_hold_duration, external_reset_merge_enable} = '0;
    {primary_reset_polarity, ext_reset_n} = 2'b11;
    gpo_data = 11'h5A3;
    lower_drive_style = 6'h0A;
    tick(5);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'h26 + 8'(i), 8'h00);
      wr(8'h26 + 8'(i), 8'hFF);
      rd(8'h26 + 8'(i), MSK[i]);
    end
    wr(8'h2C, 8'hFF);
    rd(8'h2C, 8'h00);
    // Pins: mixed drive styles, then lower and upper made inputs
    wr(8'h26, 8'h15);
    check(pin_oe, ~({5'h15, lower_drive_style} & gpo_data));
    check(pin_out, ~{5'h15, lower_drive_style} & gpo_data);
    tick(1);
    check(pin_in_level, gpo_data);
    wr(8'h27, 8'h00);
    check(pin_oe, {~(5'h15 & gpo_data[10:6]), 6'h00});
    tick(1);
    check(pin_in_level, {gpo_data[10:6], 6'h3F});
    wr(8'h28, 8'h00);
    check(pin_oe, 11'h000);
    // Trigger: code 5 active, code 6 inactive, slot three unused
    wr(8'h29, 8'h85);
    wr(8'h2A, 8'h06);
    wr(8'h2B, 8'h00);
    ev(7'h05, 1'b1, 1'b0);
    check(11'(slot_match), 11'h001);
    tick(1);
    check(11'(primary_reset_output), 11'h000);
    ev(7'h06, 1'b0, 1'b1);
    check(11'(slot_match), 11'h001);
    ev(7'h00, 1'b0, 1'b0);
    check(11'(slot_match), 11'h001);
    ev(7'h06, 1'b0, 1'b0);
    check(11'(slot_match), 11'h003);
    tick(1);
    check(11'(primary_reset_output), 11'h001);
    ev(7'h06, 1'b1, 1'b0);
    check(11'(slot_match), 11'h001);
    tick(1);
    check(11'(primary_reset_output), 11'h000);
    wr(8'h2B, 8'h87);
    ev(7'h06, 1'b0, 1'b0);
    ev(7'h07, 1'b1, 1'b1);
    check(11'(slot_match), 11'h007);
    tick(1);
    check(11'(primary_reset_output), 11'h001);
    // Each timed hold code
    for (int d = 1; d < 4; d++) begin
      ev(7'h05, 1'b0, 1'b0);
      trigger_hold_duration = 3'(d);
      ev(7'h05, 1'b1, 1'b0);
      // Output rises exactly L+1 edges after the hold starts
      tick(HL[d]);
      check(11'(primary_reset_output), 11'h000);
      tick(1);
      check(11'(primary_reset_output), 11'h001);
    end
    primary_reset_polarity = 1'b0;
    tick(1);
    check(11'(primary_reset_output), 11'h000);
    ev(7'h05, 1'b0, 1'b0);
    tick(1);
    check(11'(primary_reset_output), 11'h001);
    ext_reset_n = 1'b0;
    tick(1);
    check(11'(primary_reset_output), 11'h001);
    external_reset_merge_enable = 1'b1;
    tick(1);
    check(11'(primary_reset_output), 11'h000);
    // Reset in mid-run: slots and flags clear, merge still applies
    rst_n = 1'b0;
    tick(2);
    rst_n = 1'b1;
    rd(8'h29, 8'h00);
    check(11'(slot_match), 11'h000);
    check(11'(primary_reset_output), 11'h000);
    results();
  end
endmodule : gcr_top_bench
`default_nettype wire
